/* hw/adc_scan_pkg.sv */
// Purpose: Shared constants and carriers for the conversion scan sequencer.
// Assumes: One clock, mclk at 200 MHz; the analog core sits on the same clock.
// Notes:   Result register indices 0..7 are the analog inputs.
package adc_scan_pkg;
	localparam int          RES_W       = 12;
	localparam int          ACC_W       = 16;
	localparam int          SCAN_W      = 10;
	localparam int          CNT_W       = 8;
	localparam int          NUM_REG     = 13;
	localparam int          CONV_TIME_NS = 1400;
	localparam int          CONV_CLK_MHZ = 32;
	localparam int          CONV_CYCLES  = (CONV_TIME_NS * CONV_CLK_MHZ) / 1000;
	localparam logic [7:0]  CONV_LAST   = 8'(CONV_CYCLES - 1);
	localparam logic [3:0]  IDX_DUP     = 4'h8;
	localparam logic [3:0]  IDX_DUP_PIN = 4'h9;
	localparam logic [3:0]  IDX_DUP_TMR = 4'hA;
	localparam logic [3:0]  IDX_REF     = 4'hB;
	localparam logic [3:0]  IDX_DIAG    = 4'hC;
	localparam logic [3:0]  CH_REF      = 4'h8;
	localparam logic [3:0]  CH_DIAG     = 4'h9;

	typedef enum logic [1:0] {MODE_SINGLE, MODE_CONT, MODE_GROUP} mode_e;
	typedef enum logic [1:0] {TRG_NONE, TRG_PIN, TRG_TIMER0, TRG_TIMER1} trig_e;
	typedef enum logic [1:0] {GRP_A, GRP_B, GRP_C} group_e;

	typedef struct packed {
		mode_e           mode;
		logic            three_groups;
		logic            prio_en;
		logic            rescan_en;
		logic            rescan_first;
		logic            dbl_en;
		logic            ext_dbl_en;
		logic [2:0]      dbl_chan;
		logic            add_en;
		logic            avg_en;
		logic [3:0]      add_count;
		logic [1:0]      ratio_sel;
		logic            ref_only;
		logic            diag_en;
		logic            disc_en;
		logic            disc_precharge;
		logic            auto_clear;
		logic [2:0]      sh_mask;
		logic [7:0]      mask_a;
		logic [7:0]      mask_b;
		logic [7:0]      mask_c;
		trig_e           trig_a;
		trig_e           trig_b;
		trig_e           trig_c;
		logic [7:0][7:0] samp_states;
		logic [7:0]      samp_other;
		logic [7:0]      samp_sh;
	} scan_cfg_s;

	typedef struct packed {
		logic [3:0] channel;
		logic       sample;
		logic       convert;
		logic [2:0] sh_track;
		logic [2:0] sh_hold;
		logic       precharge;
		logic       discharge;
	} core_req_s;
endpackage

/* hw/adc_scan_sequencer.sv */
// Purpose: Scan sequencer for a 12-bit successive approximation converter, eight inputs.
// Assumes: Triggers and configuration are mclk-synchronous except the external trigger pin.
// Notes:   Conversion timing counts conversion ticks derived from mclk by the ratio select.
// How it works
// RQ1: Results are 12-bit successive approximation values.
// RQ2: Eight input, three duplicate, reference, diagnosis registers.
// RQ3: Bus to conversion clock ratio 1, 2, 4, 8.
// RQ4: Conversion lasts 1.4 us at 32 MHz.
// RQ5: Addition keeps extra bits, average optional.
// RQ6: Double trigger: first to channel, second duplicate.
// RQ7: Extended double trigger uses per-trigger duplicate registers.
// RQ8: Single scan converts once; reference conversion allowed.
// RQ9: Continuous scan repeats until stopped.
// RQ10: Group scan uses two or three groups.
// RQ11: Each group has its own start trigger.
// RQ12: Higher group trigger aborts lower group; A first.
// RQ13: Rescan resumes aborted group from first or unfinished.
// RQ14: Software, timer or active-low pin starts conversion.
// RQ15: Sampling states are set per channel.
// RQ16: Three channels sampled together, converted in turn.
// RQ17: Self-diagnosis, disconnection assist, auto clear options.
// RQ18: Plain scans raise scan end per pass.
// RQ19: Double trigger raises scan end after both scans.
// RQ20: Groups B and C have their own scan end.
// RQ21: Drive channel and sampling, capture core result.
`timescale 1ns/1ps
module adc_scan_sequencer (
	// Clock and reset.
	input  wire logic                     mclk,
	input  wire logic                     rst,
	// Configuration and software control.
	input  wire adc_scan_pkg::scan_cfg_s  cfg,
	input  wire logic                     sw_start,
	input  wire logic                     sw_stop,
	// Start triggers.
	input  wire logic [1:0]               timer_trg,
	input  wire logic                     external_convert_trigger_n,
	// Analog core.
	output adc_scan_pkg::core_req_s       core,
	input  wire logic [11:0]              core_result,
	// Result read port.
	input  wire logic                     rd_en,
	input  wire logic [3:0]               rd_idx,
	output logic [15:0]                   rd_data,
	// Status and scan end requests.
	output logic                          busy,
	output logic                          scan_end_irq,
	output logic                          group_b_scan_end_irq,
	output logic                          group_c_scan_end_irq
);
	typedef enum {ST_IDLE, ST_SH, ST_SAMPLE, ST_CONVERT, ST_STORE} state_e;

	// Lowest selected channel of a scan mask; the reference and diagnosis slots come last.
	function automatic logic [3:0] first_ch(input logic [9:0] m);
		first_ch = 4'h0;
		for (int i = adc_scan_pkg::SCAN_W - 1; i >= 0; i--) begin
			if (m[i]) begin
				first_ch = 4'(i);
			end
		end
	endfunction

	// Whether a selected trigger source fired this cycle.
	function automatic logic trig_fire(input adc_scan_pkg::trig_e s, input logic pin, input logic [1:0] t);
		case (s)
			adc_scan_pkg::TRG_PIN:    trig_fire = pin;
			adc_scan_pkg::TRG_TIMER0: trig_fire = t[0];
			adc_scan_pkg::TRG_TIMER1: trig_fire = t[1];
			default:                  trig_fire = 1'b0;
		endcase
	endfunction

	// Groups that outrank the given one.
	function automatic logic [2:0] higher_than(input adc_scan_pkg::group_e g);
		case (g)
			adc_scan_pkg::GRP_B: higher_than = 3'h1;
			adc_scan_pkg::GRP_C: higher_than = 3'h3;
			default:             higher_than = 3'h0;
		endcase
	endfunction

	state_e                    state, next_state;
	adc_scan_pkg::group_e      cur_grp, next_cur_grp;
	adc_scan_pkg::trig_e       a_src, next_a_src;
	logic [9:0]                rem, next_rem;
	logic [2:0][9:0]           resume, next_resume;
	logic [2:0]                resume_vld, next_resume_vld;
	logic [2:0]                pend, next_pend;
	logic [7:0]                cnt, next_cnt;
	logic [3:0]                rep, next_rep;
	logic [15:0]               acc, next_acc;
	logic                      sh_done, next_sh_done;
	logic                      dbl_phase, next_dbl_phase;
	logic                      next_irq_a, next_irq_b, next_irq_c;
	logic [2:0]                pin_sync;
	logic                      pin_stable;
	logic [2:0]                div;
	logic [15:0]               regs [adc_scan_pkg::NUM_REG];
	logic                      launch;
	adc_scan_pkg::group_e      pick;

	// The pin is asynchronous; a level counts only once the second and third stages agree.
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_sync   <= 3'h7;
			pin_stable <= 1'b1;
		end else begin
			pin_sync <= {pin_sync[1:0], external_convert_trigger_n};
			if (pin_sync[1] == pin_sync[2])
				pin_stable <= pin_sync[2];
		end
	end
	wire pin_fall = pin_stable && (pin_sync[1] == pin_sync[2]) && !pin_sync[2]; // RQ14

	// Conversion tick divider; only the four supported ratios exist in the select.
	wire [2:0] div_last = 3'((4'h1 << cfg.ratio_sel) - 4'h1); // RQ3
	wire       tick     = (div == div_last);
	always_ff @(posedge mclk) begin
		if (rst || tick)
			div <= 3'h0;
		else
			div <= div + 3'h1;
	end

	// Trigger decode per group; triggers for lower groups are dropped while busy.
	wire       is_grp    = (cfg.mode == adc_scan_pkg::MODE_GROUP);
	wire       dbl_act   = cfg.dbl_en && (cfg.mode != adc_scan_pkg::MODE_CONT);
	wire [2:0] trig_req;
	assign trig_req[0] = (!is_grp && sw_start) || trig_fire(cfg.trig_a, pin_fall, timer_trg); // RQ14
	assign trig_req[1] = is_grp && trig_fire(cfg.trig_b, pin_fall, timer_trg); // RQ11
	assign trig_req[2] = is_grp && cfg.three_groups && trig_fire(cfg.trig_c, pin_fall, timer_trg); // RQ10
	wire       running   = (state != ST_IDLE);
	wire [2:0] accept    = !running ? 3'h7 : (cfg.prio_en ? higher_than(cur_grp) : 3'h0);
	wire [2:0] new_req   = trig_req & accept;
	wire [2:0] pend_all  = pend | new_req;
	wire       preempt   = running && (state != ST_STORE) && cfg.prio_en
		&& |(pend_all & higher_than(cur_grp)); // RQ12
	assign pick = pend_all[0] ? adc_scan_pkg::GRP_A : (pend_all[1] ? adc_scan_pkg::GRP_B : adc_scan_pkg::GRP_C);

	// Full channel masks per group; bit 8 is the reference, bit 9 the diagnosis slot.
	wire [7:0]       dbl_hot = 8'h01 << cfg.dbl_chan;
	wire [2:0][9:0]  grp_full;
	assign grp_full[0] = dbl_act ? {2'b00, dbl_hot} // RQ6
		: (!is_grp && cfg.ref_only) ? {1'b0, 1'b1, 8'h00} // RQ8
		: {cfg.diag_en, 1'b0, cfg.mask_a}; // RQ17
	assign grp_full[1] = {2'b00, cfg.mask_b};
	assign grp_full[2] = {2'b00, cfg.mask_c};

	// Current channel, its sampling length and the end of the sampling, joint sampling and convert phases.
	wire [3:0]  ch       = first_ch(rem);
	wire [7:0]  samp_tgt = ch[3] ? cfg.samp_other : cfg.samp_states[ch[2:0]]; // RQ15
	wire        samp_end = ({1'b0, cnt} + 9'h001) >= {1'b0, samp_tgt};
	wire        sh_end   = ({1'b0, cnt} + 9'h001) >= {1'b0, cfg.samp_sh};
	wire        conv_end = tick && (cnt == adc_scan_pkg::CONV_LAST); // RQ4

	// Accumulation and result routing.
	wire [15:0] sum      = acc + {4'h0, core_result}; // RQ1
	wire        last_rep = !cfg.add_en || (rep == cfg.add_count);
	wire [2:0]  avg_sh   = (cfg.add_count == 4'hF) ? 3'h4 : (cfg.add_count == 4'h7) ? 3'h3
		: (cfg.add_count == 4'h3) ? 3'h2 : (cfg.add_count == 4'h1) ? 3'h1 : 3'h0;
	wire [15:0] store_val = (cfg.add_en && cfg.avg_en) ? (sum >> avg_sh) : sum; // RQ5
	wire        ext_route = dbl_act && cfg.ext_dbl_en && (cur_grp == adc_scan_pkg::GRP_A)
		&& (a_src == adc_scan_pkg::TRG_PIN || a_src == adc_scan_pkg::TRG_TIMER1);
	wire        dbl_grp   = dbl_act && (cur_grp == adc_scan_pkg::GRP_A);
	wire [3:0]  store_idx = (ch == adc_scan_pkg::CH_REF) ? adc_scan_pkg::IDX_REF
		: (ch == adc_scan_pkg::CH_DIAG) ? adc_scan_pkg::IDX_DIAG
		: ext_route ? ((a_src == adc_scan_pkg::TRG_PIN) ? adc_scan_pkg::IDX_DUP_PIN
			: adc_scan_pkg::IDX_DUP_TMR) // RQ7
		: (dbl_grp && dbl_phase) ? adc_scan_pkg::IDX_DUP : ch; // RQ6
	wire        store_we  = (state == ST_STORE) && last_rep; // RQ21
	wire [9:0]  rem_after = rem & ~(10'h001 << ch);
	wire [3:0]  nch       = first_ch(next_rem);
	wire        nch_held  = !nch[3] && (nch[2:0] < 3'h3) && cfg.sh_mask[nch[1:0]] && next_sh_done;

	// Sequencing decisions.
	always_comb begin
		next_state      = state;
		next_cur_grp    = cur_grp;
		next_a_src      = a_src;
		next_rem        = rem;
		next_resume     = resume;
		next_resume_vld = resume_vld;
		next_pend       = pend_all;
		next_cnt        = cnt;
		next_rep        = rep;
		next_acc        = acc;
		next_sh_done    = sh_done;
		next_dbl_phase  = dbl_phase;
		next_irq_a      = 1'b0;
		next_irq_b      = 1'b0;
		next_irq_c      = 1'b0;
		launch          = 1'b0;
		if (new_req[0])
			next_a_src = sw_start && !is_grp ? adc_scan_pkg::TRG_NONE : cfg.trig_a;
		case (state)
			ST_IDLE: begin
				launch = |pend_all;
			end
			ST_SH: begin
				if (tick && sh_end) begin
					next_sh_done = 1'b1; // RQ16
					next_cnt     = 8'h00;
					next_state   = nch_held ? ST_CONVERT : ST_SAMPLE;
				end else if (tick) begin
					next_cnt = cnt + 8'h01;
				end
			end
			ST_SAMPLE: begin
				if (tick && samp_end) begin
					next_cnt   = 8'h00;
					next_state = ST_CONVERT;
				end else if (tick) begin
					next_cnt = cnt + 8'h01;
				end
			end
			ST_CONVERT: begin
				if (conv_end) begin
					next_cnt   = 8'h00;
					next_state = ST_STORE;
				end else if (tick) begin
					next_cnt = cnt + 8'h01;
				end
			end
			ST_STORE: begin
				next_acc = last_rep ? 16'h0000 : sum;
				next_rep = last_rep ? 4'h0 : rep + 4'h1;
				if (last_rep)
					next_rem = rem_after;
				if (|next_rem) begin
					next_state = nch_held ? ST_CONVERT : ST_SAMPLE;
				end else begin
					next_sh_done = 1'b0;
					if (cur_grp == adc_scan_pkg::GRP_A) begin
						next_irq_a = !dbl_grp || ext_route || dbl_phase; // RQ18 RQ19
						if (dbl_grp && !ext_route)
							next_dbl_phase = !dbl_phase;
					end
					next_irq_b = (cur_grp == adc_scan_pkg::GRP_B); // RQ20
					next_irq_c = (cur_grp == adc_scan_pkg::GRP_C); // RQ20
					if (cfg.mode == adc_scan_pkg::MODE_CONT) begin
						next_rem   = grp_full[0]; // RQ9
						next_state = |(grp_full[0][2:0] & cfg.sh_mask) ? ST_SH : ST_SAMPLE; // RQ16
					end else begin
						next_state = ST_IDLE; // RQ8
						launch     = |pend_all;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// A higher group aborts the running one; its unfinished channels include the current one.
		if (preempt) begin
			launch = 1'b1;
			next_sh_done = 1'b0;
			if (cfg.rescan_en) begin
				next_resume[cur_grp]     = cfg.rescan_first ? grp_full[cur_grp] : rem; // RQ13
				next_resume_vld[cur_grp] = 1'b1;
				next_pend[cur_grp]       = 1'b1;
			end
		end
		if (launch) begin
			next_cur_grp          = pick;
			next_pend[pick]       = 1'b0;
			next_resume_vld[pick] = 1'b0;
			next_rem   = resume_vld[pick] ? resume[pick] : grp_full[pick];
			next_cnt   = 8'h00;
			next_rep   = 4'h0;
			next_acc   = 16'h0000;
			next_state = |(next_rem[2:0] & cfg.sh_mask) ? ST_SH : ST_SAMPLE;
		end
		if (sw_stop) begin
			next_state      = ST_IDLE;
			next_pend       = 3'h0;
			next_resume_vld = 3'h0;
			next_sh_done    = 1'b0;
			next_dbl_phase  = 1'b0;
		end
	end

	// Sequencer state.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state      <= ST_IDLE;
			cur_grp    <= adc_scan_pkg::GRP_A;
			a_src      <= adc_scan_pkg::TRG_NONE;
			rem        <= 10'h000;
			resume     <= '0;
			resume_vld <= 3'h0;
			pend       <= 3'h0;
			cnt        <= 8'h00;
			rep        <= 4'h0;
			acc        <= 16'h0000;
			sh_done    <= 1'b0;
			dbl_phase  <= 1'b0;
		end else begin
			state      <= next_state;
			cur_grp    <= next_cur_grp;
			a_src      <= next_a_src;
			rem        <= next_rem;
			resume     <= next_resume;
			resume_vld <= next_resume_vld;
			pend       <= next_pend;
			cnt        <= next_cnt;
			rep        <= next_rep;
			acc        <= next_acc;
			sh_done    <= next_sh_done;
			dbl_phase  <= next_dbl_phase;
		end
	end

	// Core requests follow the next state so they line up with the sequencer state.
	wire [3:0] out_ch = first_ch(next_rem);
	wire       samp_n = (next_state == ST_SAMPLE);
	always_ff @(posedge mclk) begin
		if (rst) begin
			core                 <= '0;
			busy                 <= 1'b0;
			scan_end_irq         <= 1'b0;
			group_b_scan_end_irq <= 1'b0;
			group_c_scan_end_irq <= 1'b0;
		end else begin
			core.channel   <= out_ch; // RQ21
			core.sample    <= samp_n;
			core.convert   <= (next_state == ST_CONVERT);
			core.sh_track  <= (next_state == ST_SH) ? (next_rem[2:0] & cfg.sh_mask) : 3'h0; // RQ16
			core.sh_hold   <= next_sh_done ? cfg.sh_mask : 3'h0;
			core.precharge <= samp_n && (next_cnt == 8'h00) && cfg.disc_en && cfg.disc_precharge; // RQ17
			core.discharge <= samp_n && (next_cnt == 8'h00) && cfg.disc_en && !cfg.disc_precharge;
			busy                 <= (next_state != ST_IDLE);
			scan_end_irq         <= next_irq_a;
			group_b_scan_end_irq <= next_irq_b;
			group_c_scan_end_irq <= next_irq_c;
		end
	end

	// Result registers; a store in the same cycle as an auto clear of that entry wins.
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < adc_scan_pkg::NUM_REG; i++)
				regs[i] <= 16'h0000; // RQ2
			rd_data <= 16'h0000;
		end else begin
			if (rd_en)
				rd_data <= (rd_idx < 4'(adc_scan_pkg::NUM_REG)) ? regs[rd_idx] : 16'h0000;
			if (rd_en && cfg.auto_clear && (rd_idx < 4'(adc_scan_pkg::NUM_REG)))
				regs[rd_idx] <= 16'h0000; // RQ17
			if (store_we)
				regs[store_idx] <= store_val; // RQ2
		end
	end
endmodule

/* sim/adc_core_model.sv */
// Purpose: Behavioural analog core answering each convert window.
// Assumes: The result is taken in the first cycle after convert drops.
// Notes:   Outside that cycle the bus shows a moving pattern, never a stale value.
`timescale 1ns/1ps
module adc_core_model (
	// Clock and sequencer requests.
	input  wire logic                    mclk,
	input  wire adc_scan_pkg::core_req_s core,
	// Low byte of the answer, set by the bench.
	input  wire logic [7:0]              lo,
	// Result back to the sequencer.
	output logic [11:0]                  core_result
);
	logic        was_conv = 1'b0;
	logic [11:0] junk     = 12'hA5A;
	// Keep the idle pattern moving so a capture in the wrong cycle is caught.
	always_ff @(posedge mclk) begin
		was_conv <= core.convert;
		junk     <= ~junk + 12'h001;
	end
	// The channel sits in the top nibble so a result stored in the wrong slot shows.
	assign core_result = (was_conv && !core.convert) ? {core.channel, lo} : junk;
endmodule

/* sim/adc_scan_chk.sv */
// Purpose: Port-level assertions for the scan sequencer.
// Assumes: One mclk domain with synchronous active-high reset.
// Notes:   Attached by bind below; sees top-level ports only.
`timescale 1ns/1ps
module adc_scan_chk (
	// Clock and control.
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire adc_scan_pkg::scan_cfg_s cfg,
	input wire logic                    sw_start,
	input wire logic                    sw_stop,
	// Read port.
	input wire logic                    rd_en,
	input wire logic [3:0]              rd_idx,
	input wire logic [15:0]             rd_data,
	// Core side and status.
	input wire adc_scan_pkg::core_req_s core,
	input wire logic                    busy,
	input wire logic                    scan_end_irq,
	input wire logic                    group_b_scan_end_irq,
	input wire logic                    group_c_scan_end_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [7:0] conv_len;
	logic       stopped;
	// Convert window length, and a flag for scans cut short, which legally end early.
	always_ff @(posedge mclk) begin
		conv_len <= (core.convert && !rst) ? conv_len + 8'h01 : 8'h00;
		stopped  <= !rst && (sw_stop || (stopped && busy));
	end
	AST_START: assert property (!busy && sw_start && !sw_stop && cfg.sh_mask == 3'h0
		&& cfg.mode == adc_scan_pkg::MODE_SINGLE |=> busy && core.sample) else $error("no sampling after start");
	AST_CONV_LEN: assert property ($fell(core.convert) && cfg.ratio_sel == 2'h0 && !cfg.prio_en && !stopped
		|-> conv_len == adc_scan_pkg::CONV_LAST + 8'h01) else $error("convert window length wrong");
	AST_END_ORDER: assert property ((scan_end_irq || group_b_scan_end_irq || group_c_scan_end_irq)
		|-> $past(core.convert, 2) && !$past(core.convert)) else $error("scan end not after store");
	AST_END_PULSE: assert property (scan_end_irq |=> !scan_end_irq) else $error("scan end too long");
	AST_B_END: assert property (group_b_scan_end_irq |-> cfg.mode == adc_scan_pkg::MODE_GROUP)
		else $error("group b end outside group mode");
	AST_C_END: assert property (group_c_scan_end_irq |-> cfg.three_groups
		&& cfg.mode == adc_scan_pkg::MODE_GROUP) else $error("group c end without three groups");
	AST_ONE_END: assert property ($onehot0({scan_end_irq, group_b_scan_end_irq, group_c_scan_end_irq}))
		else $error("two scan ends at once");
	AST_SINGLE_STOP: assert property (scan_end_irq && cfg.mode == adc_scan_pkg::MODE_SINGLE |-> !busy)
		else $error("single scan kept running");
	AST_CONT_RUN: assert property (scan_end_irq && cfg.mode == adc_scan_pkg::MODE_CONT && !$past(sw_stop)
		&& !$past(sw_stop, 2) |-> busy) else $error("continuous scan stopped");
	AST_RD_RANGE: assert property (rd_en && rd_idx > 4'hC |=> rd_data == 16'h0000)
		else $error("unused index read nonzero");
	AST_EXCL: assert property (!(core.sample && core.convert)) else $error("sample and convert overlap");
	AST_PRECHARGE: assert property (core.precharge |-> core.sample && cfg.disc_en && cfg.disc_precharge)
		else $error("precharge outside sampling");
	AST_DISCHARGE: assert property (core.discharge |-> core.sample && cfg.disc_en && !cfg.disc_precharge)
		else $error("discharge outside sampling");
	AST_SH_HOLD: assert property (core.sh_hold != 3'h0 |-> busy && core.sh_hold == cfg.sh_mask
		&& core.sh_track == 3'h0) else $error("hold outside a running pass");
	AST_SH_TRACK: assert property (core.sh_track != 3'h0 |-> !core.sample && !core.convert
		&& (core.sh_track & ~cfg.sh_mask) == 3'h0) else $error("joint sampling on unheld channel");
endmodule
bind adc_scan_sequencer adc_scan_chk chk (.mclk, .rst, .cfg, .sw_start, .sw_stop, .rd_en, .rd_idx, .rd_data,
	.core, .busy, .scan_end_irq, .group_b_scan_end_irq, .group_c_scan_end_irq);

/* sim/test_adc_scan_sequencer.sv */
// Purpose: Self-checking bench for the scan sequencer with a core model.
// Assumes: Inputs change on the falling edge; fixed seed for repeatable runs.
// Notes:   Expected results are the channel number over the model's low byte.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_adc_scan_sequencer;
	logic                    mclk, rst, sw_start, sw_stop, rd_en, busy, external_convert_trigger_n;
	logic                    scan_end_irq, group_b_scan_end_irq, group_c_scan_end_irq;
	adc_scan_pkg::scan_cfg_s cfg;
	adc_scan_pkg::core_req_s core;
	logic [1:0]              timer_trg;
	logic [2:0]              irqs;
	logic [3:0]              rd_idx;
	logic [7:0]              lo;
	logic [11:0]             core_result;
	logic [15:0]             rd_data, v;
	int                      checks, n_mismatch, cyc, n_a, n_b, n0;
	integer                  seed = 32'h3227;
	assign irqs = {group_c_scan_end_irq, group_b_scan_end_irq, scan_end_irq};
	adc_scan_sequencer dut (.mclk, .rst, .cfg, .sw_start, .sw_stop, .timer_trg, .external_convert_trigger_n, .core,
		.core_result, .rd_en, .rd_idx, .rd_data, .busy, .scan_end_irq, .group_b_scan_end_irq, .group_c_scan_end_irq);
	adc_core_model model (.mclk, .core, .lo, .core_result);
	// Clock, 5 ns period.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Count group A and B scan ends; a run far past its expected length is a hang.
	always @(posedge mclk) begin
		cyc++;
		n_a += int'(scan_end_irq === 1'b1);
		n_b += int'(group_b_scan_end_irq === 1'b1);
		if (cyc == 90000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	function automatic logic [15:0] val(logic [3:0] ch);
		return {4'h0, ch, lo};
	endfunction
	task automatic tick(int n = 1);
		repeat (n) @(negedge mclk);
	endtask
	// Source 0 software, 1 pin, 2 and 3 timer pulses; a new answer byte each time.
	task automatic go(int src);
		lo = 8'($random(seed));
		if (src == 0) sw_start = 1'b1;
		else if (src == 1) external_convert_trigger_n = 1'b0;
		else timer_trg = 2'(1 << (src - 2));
		tick(src == 1 ? 3 : 1);
		sw_start = 1'b0;
		external_convert_trigger_n = 1'b1;
		timer_trg = 2'h0;
	endtask
	// Wait for scan end k, or for idle when k is 3, bounded.
	task automatic wait_for(int k);
		int n;
		n = 0;
		while ((k < 3 ? irqs[k] : !busy) !== 1'b1 && n < 20000) begin
			tick();
			n++;
		end
		`CHK(n < 20000, 1'b1)
		tick();
	endtask
	task automatic rd(logic [3:0] i, logic [15:0] e);
		rd_en = 1'b1;
		rd_idx = i;
		tick();
		rd_en = 1'b0;
		tick();
		`CHK(rd_data, e)
	endtask
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence; configuration only changes while idle.
	initial begin
		{sw_start, sw_stop, rd_en, timer_trg, rd_idx, lo} = '0;
		external_convert_trigger_n = 1'b1;
		rst = 1'b1;
		cfg = '0;
		tick(4);
		rst = 1'b0;
		tick();
		for (int i = 0; i < 6; i++) begin
			cfg = '0;
			cfg.mask_a = i == 0 ? 8'hFF : 8'($random(seed)) | 8'h01;
			{cfg.sh_mask, cfg.disc_en, cfg.disc_precharge, cfg.ratio_sel} = 7'($random(seed)) | 7'(i == 0 ? 3 : 0);
			cfg.samp_sh = 8'h03;
			for (int c = 0; c < 8; c++) cfg.samp_states[c] = 8'($random(seed)) & 8'h07;
			go(0);
			wait_for(0);
			`CHK(busy, 1'b0)
			for (int c = 0; c < 8; c++) if (cfg.mask_a[c]) rd(4'(c), val(4'(c)));
		end
		$display("test single done");
		// A reference-only pass replaces the inputs, so the diagnosis slot gets a pass of its own.
		cfg = '0;
		cfg.ref_only = 1'b1;
		go(0);
		wait_for(0);
		rd(adc_scan_pkg::IDX_REF, val(adc_scan_pkg::CH_REF));
		{cfg.ref_only, cfg.diag_en, cfg.mask_a} = {2'h1, 8'h01};
		go(0);
		wait_for(0);
		rd(adc_scan_pkg::IDX_DIAG, val(adc_scan_pkg::CH_DIAG));
		rd(4'h0, val(4'h0));
		$display("test reference done");
		cfg = '0;
		{cfg.add_en, cfg.mask_a} = {1'b1, 8'h04};
		for (int k = 0; k < 4; k++) begin
			cfg.add_count = k[0] ? 4'h3 : 4'h1;
			cfg.avg_en = k[1];
			go(0);
			wait_for(0);
			rd(4'h2, k[1] ? val(4'h2) : val(4'h2) * (k[0] ? 16'h4 : 16'h2));
		end
		$display("test addition done");
		cfg = '0;
		{cfg.dbl_en, cfg.dbl_chan, cfg.mask_a} = {1'b1, 3'h5, 8'h20};
		n0 = n_a;
		go(0);
		wait_for(3);
		`CHK(n_a, n0)
		v = val(4'h5);
		go(0);
		wait_for(0);
		rd(4'h5, v);
		rd(adc_scan_pkg::IDX_DUP, val(4'h5));
		cfg.ext_dbl_en = 1'b1;
		for (int t = 0; t < 2; t++) begin
			cfg.trig_a = t ? adc_scan_pkg::TRG_TIMER1 : adc_scan_pkg::TRG_PIN;
			go(t ? 3 : 1);
			wait_for(0);
			rd(t ? adc_scan_pkg::IDX_DUP_TMR : adc_scan_pkg::IDX_DUP_PIN, val(4'h5));
		end
		$display("test double done");
		cfg = '0;
		cfg.mode = adc_scan_pkg::MODE_CONT;
		cfg.mask_a = 8'h03;
		go(0);
		wait_for(0);
		wait_for(0);
		`CHK(busy, 1'b1)
		sw_stop = 1'b1;
		tick();
		sw_stop = 1'b0;
		wait_for(3);
		$display("test continuous done");
		cfg = '0;
		cfg.mode = adc_scan_pkg::MODE_GROUP;
		{cfg.three_groups, cfg.mask_a, cfg.mask_b, cfg.mask_c} = {1'b1, 24'h010204};
		cfg.trig_a = adc_scan_pkg::TRG_PIN;
		cfg.trig_b = adc_scan_pkg::TRG_TIMER0;
		cfg.trig_c = adc_scan_pkg::TRG_TIMER1;
		go(0);
		tick(4);
		`CHK(busy, 1'b0)
		for (int g = 0; g < 3; g++) begin
			go(g + 1);
			wait_for(g);
			rd(4'(g), val(4'(g)));
		end
		cfg.three_groups = 1'b0;
		go(3);
		tick(4);
		`CHK(busy, 1'b0)
		{cfg.three_groups, cfg.prio_en, cfg.mask_b} = {2'h3, 8'hF0};
		cfg.trig_c = adc_scan_pkg::TRG_NONE;
		for (int r = 0; r < 3; r++) begin
			cfg.rescan_en = r < 2;
			cfg.rescan_first = r == 1;
			n0 = n_b;
			go(2);
			tick(100);
			go(1);
			wait_for(0);
			`CHK(n_b, n0)
			wait_for(r < 2 ? 1 : 3);
			`CHK(n_b, n0 + int'(r < 2))
			if (r < 2) rd(4'h7, val(4'h7));
		end
		$display("test groups done");
		cfg = '0;
		{cfg.auto_clear, cfg.mask_a} = {1'b1, 8'h01};
		go(0);
		wait_for(0);
		rd(4'h0, val(4'h0));
		rd(4'h0, 16'h0000);
		for (int i = 13; i < 16; i++) rd(4'(i), 16'h0000);
		$display("test clear done");
		wrap_up();
	end
endmodule
